// [crf_filter.sv]
// Receive identifier acceptance filter with bus-off hold flag and error counter view.
// Assumes the protocol engine delivers identifier bytes with a one-cycle complete strobe.
// Operation
// RQ1: Writing one clears hold flag; zero ignored.
// RQ2: Recovery option set: flag set entering bus-off.
// RQ3: Clearing flag requests recovery, reads zero.
// RQ4: Receive counter read-only, readable sleep/init only.
// RQ5: Transmit counter same read restriction.
// RQ6: Software reads counters only in sleep/init.
// RQ7: Store all messages; signal only accepted ones. Code also flags rejected ones in IRQ_DROP status.
// RQ8: Rejected message overwritten, no signal. Code sets IRQ_DROP status, raising irq when masked in.
// RQ9: Compare pattern bits to identifier byte, masked.
// RQ10: Extended uses four bytes, standard two.
// RQ11: Filter registers writable only in init mode.
// RQ12: Mask clear requires match; set ignores bit.
// RQ13: Standard in 32-bit: ignore low bits.
// RQ14: Standard in 16-bit: ignore low bits.
// RQ15: Organisation field selects filter arrangement.
// RQ16: Closed filter accepts nothing.
// RQ17: Hit index tracks foreground message.
// RQ18: Without recovery option flag reads zero.
`timescale 1ns/100ps
module crf_filter
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	input wire logic init_request,
	input wire logic init_acknowledge,
	input wire logic sleep_request,
	input wire logic sleep_acknowledge,
	input wire logic user_recovery_option,
	input wire logic busOffEnter,
	output logic recoveryRequest,
	input wire logic [7:0] rxErrCount,
	input wire logic [7:0] txErrCount,
	input wire logic rxDone,
	input wire logic rxExtended,
	input wire logic [31:0] message_identifier_bytes,
	output logic [31:0] backgroundId,
	output logic foregroundLoad,
	output logic [31:0] foreground_receive_buffer,
	output logic irq
);
	typedef struct packed {
		logic [7:0][7:0] pattern;
		logic [7:0][7:0] ignore;
		logic [1:0] org;
		logic [2:0] hit;
		logic hold;
		logic recov;
		logic [2:0] stat;
		logic [2:0] mask;
		logic [31:0] bgId;
		logic fgLoad;
		logic [31:0] fgId;
		logic [7:0] rdData;
	} crf_state_type;

	crf_state_type stateFf;
	crf_state_type nxtState;

	// Matches one identifier byte against one pattern byte under its mask.
	function automatic logic byteHit(input logic [7:0] id, input logic [7:0] pat, input logic [7:0] ign);
		byteHit = &(~(id ^ pat) | ign); // [RQ9] [RQ12]
	endfunction

	function automatic logic isPatternAddr(input logic [4:0] addr);
		isPatternAddr = addr[4:3] == crf_pkg::OFS_PATTERN[4:3];
	endfunction

	function automatic logic isIgnoreAddr(input logic [4:0] addr);
		isIgnoreAddr = addr[4:3] == crf_pkg::OFS_IGNORE[4:3];
	endfunction

	logic inInit;
	logic inSleep;
	logic [7:0] hitVec;
	logic accept;
	logic [2:0] hitIdx;
	logic [7:0] idb [4];

	assign inInit = init_request & init_acknowledge;
	assign inSleep = sleep_request & sleep_acknowledge;

	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			idb[b] = message_identifier_bytes[31 - 8 * b -: 8];
		end
		hitVec = 8'h00;
		unique case (crf_pkg::crf_org_type'(stateFf.org)) // [RQ15]
			crf_pkg::ORG_32:
			begin
				for (int f = 0; f < 2; f++)
				begin
					// Standard frames carry only two identifier bytes. [RQ10]
					hitVec[f] = byteHit(idb[0], stateFf.pattern[4 * f], stateFf.ignore[4 * f])
						& byteHit(idb[1], stateFf.pattern[4 * f + 1], stateFf.ignore[4 * f + 1])
						& (~rxExtended | (byteHit(idb[2], stateFf.pattern[4 * f + 2], stateFf.ignore[4 * f + 2])
						& byteHit(idb[3], stateFf.pattern[4 * f + 3], stateFf.ignore[4 * f + 3])));
				end
			end
			crf_pkg::ORG_16:
			begin
				for (int f = 0; f < 4; f++)
				begin
					hitVec[f] = byteHit(idb[0], stateFf.pattern[2 * f], stateFf.ignore[2 * f])
						& byteHit(idb[1], stateFf.pattern[2 * f + 1], stateFf.ignore[2 * f + 1]);
				end
			end
			crf_pkg::ORG_8:
			begin
				for (int f = 0; f < 8; f++)
				begin
					hitVec[f] = byteHit(idb[0], stateFf.pattern[f], stateFf.ignore[f]);
				end
			end
			crf_pkg::ORG_CLOSED:
			begin
				hitVec = 8'h00; // [RQ16]
			end
		endcase
		accept = |hitVec;
		hitIdx = 3'h0;
		for (int f = 7; f >= 0; f--)
		begin
			if (hitVec[f])
			begin
				hitIdx = 3'(f);
			end
		end
	end

	always_comb
	begin
		nxtState = stateFf;
		nxtState.fgLoad = 1'h0;
		nxtState.recov = 1'h0;
		nxtState.rdData = 8'h00;
		if (rxDone)
		begin
			// Every frame lands in the background slot; a rejected one is simply overwritten later. [RQ7] [RQ8]
			nxtState.bgId = message_identifier_bytes;
			if (accept)
			begin
				nxtState.fgLoad = 1'h1;
				nxtState.fgId = message_identifier_bytes;
				nxtState.hit = hitIdx; // [RQ17]
			end
		end
		if (regWrStb)
		begin
			// Without the option a clear would ask the engine to leave a hold it never entered.
			if (regAddr == crf_pkg::OFS_MISC && regWrData[crf_pkg::BIT_HOLD] && stateFf.hold && user_recovery_option)
			begin
				nxtState.hold = 1'h0; // [RQ1] [RQ3]
				nxtState.recov = 1'h1;
			end
			if (inInit) // [RQ11]
			begin
				if (regAddr == crf_pkg::OFS_CTRL)
				begin
					nxtState.org = regWrData[crf_pkg::CTRL_ORG_LO +: 2];
				end
				if (isPatternAddr(regAddr))
				begin
					nxtState.pattern[regAddr[2:0]] = regWrData;
				end
				if (isIgnoreAddr(regAddr))
				begin
					nxtState.ignore[regAddr[2:0]] = regWrData;
				end
			end
			if (regAddr == crf_pkg::OFS_IRQ_STAT)
			begin
				nxtState.stat = stateFf.stat & ~regWrData[2:0];
			end
			if (regAddr == crf_pkg::OFS_IRQ_MASK)
			begin
				nxtState.mask = regWrData[2:0];
			end
		end
		// Set is applied after any clear so a coincident event is never lost.
		if (busOffEnter && user_recovery_option)
		begin
			nxtState.hold = 1'h1; // [RQ2]
		end
		if (!user_recovery_option)
		begin
			nxtState.hold = 1'h0; // [RQ18]
		end
		nxtState.stat[crf_pkg::IRQ_ACCEPT] = nxtState.stat[crf_pkg::IRQ_ACCEPT] | (rxDone & accept);
		nxtState.stat[crf_pkg::IRQ_DROP] = nxtState.stat[crf_pkg::IRQ_DROP] | (rxDone & ~accept);
		nxtState.stat[crf_pkg::IRQ_BUSOFF] = nxtState.stat[crf_pkg::IRQ_BUSOFF] | busOffEnter;
		if (regRdStb)
		begin
			unique case (regAddr)
				crf_pkg::OFS_MISC:
					nxtState.rdData = {7'h00, stateFf.hold};
				crf_pkg::OFS_RXERR:
					// Outside sleep or init the live counter may be mid-update, so zero is returned. [RQ4] [RQ6]
					nxtState.rdData = (inInit | inSleep) ? rxErrCount : 8'h00;
				crf_pkg::OFS_TXERR:
					nxtState.rdData = (inInit | inSleep) ? txErrCount : 8'h00; // [RQ5]
				crf_pkg::OFS_CTRL:
					nxtState.rdData = {2'h0, stateFf.org, 1'h0, stateFf.hit};
				crf_pkg::OFS_IRQ_STAT:
					nxtState.rdData = {5'h00, stateFf.stat};
				crf_pkg::OFS_IRQ_MASK:
					nxtState.rdData = {5'h00, stateFf.mask};
				default:
				begin
					if (isPatternAddr(regAddr))
					begin
						nxtState.rdData = stateFf.pattern[regAddr[2:0]];
					end
					else if (isIgnoreAddr(regAddr))
					begin
						nxtState.rdData = stateFf.ignore[regAddr[2:0]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stateFf <= '0;
		end
		else
		begin
			stateFf <= nxtState;
		end
	end

	assign regRdData = stateFf.rdData;
	assign recoveryRequest = stateFf.recov;
	assign backgroundId = stateFf.bgId;
	assign foregroundLoad = stateFf.fgLoad;
	assign foreground_receive_buffer = stateFf.fgId;
	assign irq = |(stateFf.stat & stateFf.mask);
endmodule

// [crf_pkg.sv]
// Package for the receive identifier filter and error status block.
// Assumes a byte-wide register port with one-cycle read latency.
package crf_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_MISC = 5'h00;
	localparam logic [4:0] OFS_RXERR = 5'h01;
	localparam logic [4:0] OFS_TXERR = 5'h02;
	localparam logic [4:0] OFS_CTRL = 5'h03;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h04;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h05;
	localparam logic [4:0] OFS_PATTERN = 5'h08;
	localparam logic [4:0] OFS_IGNORE = 5'h10;
	localparam int BIT_HOLD = 0;
	localparam int BIT_RECOV = 0;
	localparam int CTRL_ORG_LO = 4;
	localparam int CTRL_HIT_LO = 0;
	localparam int IRQ_ACCEPT = 0;
	localparam int IRQ_BUSOFF = 1;
	localparam int IRQ_DROP = 2;
	localparam logic [7:0] RST_PATTERN = 8'h00;
	localparam logic [7:0] RST_IGNORE = 8'h00;
	typedef enum logic [1:0] {
		ORG_32 = 2'h0,
		ORG_16 = 2'h1,
		ORG_8 = 2'h2,
		ORG_CLOSED = 2'h3
	} crf_org_type;
endpackage

// [crf_engine_model.sv]
// Protocol engine stand-in: delivers identifiers, bus-off events and counters.
// Assumes the bench calls its tasks in step with clk_sys.
`timescale 1ns/100ps
module crf_engine_model
(
	input wire logic clk_sys,
	output logic rxDone,
	output logic rxExtended,
	output logic [31:0] message_identifier_bytes,
	output logic busOffEnter,
	output logic [7:0] rxErrCount,
	output logic [7:0] txErrCount
);
	initial {rxDone, rxExtended, message_identifier_bytes, busOffEnter, rxErrCount, txErrCount} = 51'h2A5C;
	task automatic send(input logic [31:0] id, input logic ext);
		@(posedge clk_sys);
		{rxDone, rxExtended, message_identifier_bytes} <= {1'h1, ext, id};
		@(posedge clk_sys);
		rxDone <= 1'h0;
		// Stale identifier bits are inverted so a late sample cannot pass.
		message_identifier_bytes <= ~id;
	endtask
	task automatic busOff();
		@(posedge clk_sys);
		busOffEnter <= 1'h1;
		@(posedge clk_sys);
		busOffEnter <= 1'h0;
	endtask
endmodule

// [crf_filter_chk.sv]
// Port checker for the identifier filter.
// Assumes the bind below; one clock domain.
`timescale 1ns/100ps
module crf_filter_chk
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regRdData,
	input wire logic init_request,
	input wire logic sleep_request,
	input wire logic user_recovery_option,
	input wire logic recoveryRequest,
	input wire logic rxDone,
	input wire logic [31:0] message_identifier_bytes,
	input wire logic [31:0] backgroundId,
	input wire logic foregroundLoad,
	input wire logic [31:0] foreground_receive_buffer
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_bg_capture: assert property (rxDone |=> backgroundId == $past(message_identifier_bytes)) else $error("bg");
	a_load_cause: assert property (foregroundLoad |-> $past(rxDone)) else $error("load");
	a_load_value: assert property (foregroundLoad
		|-> foreground_receive_buffer == $past(message_identifier_bytes)) else $error("fg value");
	a_fg_hold: assert property (!$stable(foreground_receive_buffer) |-> foregroundLoad) else $error("fg");
	a_recov_cause: assert property (recoveryRequest
		|-> $past(regWrStb) && $past(regAddr) == crf_pkg::OFS_MISC && $past(regWrData[0])) else $error("recov");
	a_recov_option: assert property (recoveryRequest |-> $past(user_recovery_option)) else $error("opt");
	a_rx_hidden: assert property (regRdStb && regAddr == crf_pkg::OFS_RXERR && !init_request && !sleep_request
		|=> regRdData == 8'h00) else $error("rx cnt");
	a_tx_hidden: assert property (regRdStb && regAddr == crf_pkg::OFS_TXERR && !init_request && !sleep_request
		|=> regRdData == 8'h00) else $error("tx cnt");
	cover property (foregroundLoad);
	cover property (rxDone ##1 !foregroundLoad);
	cover property (recoveryRequest);
endmodule
bind crf_filter crf_filter_chk u_chk (.*);

// [tb_top.sv]
// Register-level bench for the identifier filter.
// Assumes the engine model drives the receive side.
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 1'h0;
	logic arst_n = 1'h0;
	logic regWrStb = 1'h0;
	logic regRdStb = 1'h0;
	logic user_recovery_option = 1'h0;
	logic init_request = 1'h0, init_acknowledge = 1'h0, sleep_request = 1'h0, sleep_acknowledge = 1'h0;
	logic [4:0] regAddr = 5'h00;
	logic [7:0] regWrData = 8'h00, regRdData, rxErrCount, txErrCount;
	logic [31:0] message_identifier_bytes, backgroundId, foreground_receive_buffer;
	logic busOffEnter, recoveryRequest, rxDone, rxExtended, foregroundLoad, irq;
	int nFail = 0;
	int testsRun = 0;
	crf_engine_model u_eng (.*);
	crf_filter u_dut (.*);
	initial
		forever #5 clk_sys = ~clk_sys;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		testsRun++;
		if (s !== e)
		begin
			nFail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{regWrStb, regAddr, regWrData} <= {1'h1, a, d};
		@(posedge clk_sys);
		regWrStb <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		{regRdStb, regAddr} <= {1'h1, a};
		@(posedge clk_sys);
		regRdStb <= 1'h0;
		#1 chk("regRdData", {24'h0, e}, {24'h0, regRdData});
	endtask
	task automatic rx(input logic [31:0] id, input logic ext, input logic ld, input logic [31:0] f);
		u_eng.send(id, ext);
		#1 chk("foregroundLoad", {31'h0, ld}, {31'h0, foregroundLoad});
		chk("foreground_receive_buffer", f, foreground_receive_buffer);
		chk("backgroundId", id, backgroundId);
	endtask
	task automatic org(input logic [7:0] d);
		{init_request, init_acknowledge} <= 2'h3;
		wr(crf_pkg::OFS_CTRL, d);
		{init_request, init_acknowledge} <= 2'h0;
	endtask
	task automatic summarize();
		if (nFail == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'h1;
		wr(crf_pkg::OFS_PATTERN, 8'h12);
		rd(crf_pkg::OFS_PATTERN, 8'h00);
		rd(crf_pkg::OFS_RXERR, 8'h00);
		rd(crf_pkg::OFS_TXERR, 8'h00);
		rd(5'h1F, 8'h00);
		{sleep_request, sleep_acknowledge} <= 2'h3;
		rd(crf_pkg::OFS_RXERR, 8'h2A);
		{sleep_request, sleep_acknowledge, init_request, init_acknowledge} <= 4'h3;
		wr(crf_pkg::OFS_TXERR, 8'hFF);
		rd(crf_pkg::OFS_TXERR, 8'h5C);
		wr(crf_pkg::OFS_IRQ_MASK, 8'h01);
		wr(crf_pkg::OFS_PATTERN, 8'h12);
		wr(crf_pkg::OFS_PATTERN + 5'h01, 8'h34);
		wr(crf_pkg::OFS_PATTERN + 5'h03, 8'h55);
		wr(crf_pkg::OFS_IGNORE + 5'h01, 8'h07);
		wr(crf_pkg::OFS_IGNORE + 5'h05, 8'h07);
		wr(crf_pkg::OFS_IGNORE + 5'h03, 8'h07);
		wr(crf_pkg::OFS_IGNORE + 5'h07, 8'h07);
		{init_request, init_acknowledge} <= 2'h0;
		rd(crf_pkg::OFS_IGNORE + 5'h01, 8'h07);
		rx(32'h12340055, 1'h1, 1'h1, 32'h12340055);
		chk("irq", 32'h1, {31'h0, irq});
		wr(crf_pkg::OFS_IRQ_STAT, 8'h07);
		#1 chk("irq", 32'h0, {31'h0, irq});
		rx(32'h12340001, 1'h1, 1'h0, 32'h12340055);
		rx(32'h12B40000, 1'h0, 1'h0, 32'h12340055);
		rx(32'h00000000, 1'h1, 1'h1, 32'h00000000);
		rd(crf_pkg::OFS_CTRL, 8'h01);
		rx(32'h1237FFFF, 1'h0, 1'h1, 32'h1237FFFF);
		rd(crf_pkg::OFS_CTRL, 8'h00);
		org(8'h10);
		rx(32'h00550000, 1'h0, 1'h1, 32'h00550000);
		rd(crf_pkg::OFS_CTRL, 8'h11);
		org(8'h20);
		rx(32'h55000000, 1'h0, 1'h1, 32'h55000000);
		rd(crf_pkg::OFS_CTRL, 8'h23);
		org(8'h30);
		rx(32'h55AA0000, 1'h1, 1'h0, 32'h55000000);
		user_recovery_option <= 1'h1;
		u_eng.busOff();
		rd(crf_pkg::OFS_MISC, 8'h01);
		wr(crf_pkg::OFS_MISC, 8'h00);
		rd(crf_pkg::OFS_MISC, 8'h01);
		wr(crf_pkg::OFS_MISC, 8'h01);
		#1 chk("recoveryRequest", 32'h1, {31'h0, recoveryRequest});
		rd(crf_pkg::OFS_MISC, 8'h00);
		user_recovery_option <= 1'h0;
		u_eng.busOff();
		rd(crf_pkg::OFS_MISC, 8'h00);
		rd(crf_pkg::OFS_IRQ_STAT, 8'h07);
		wr(crf_pkg::OFS_IRQ_STAT, 8'h02);
		rd(crf_pkg::OFS_IRQ_STAT, 8'h05);
		rd(crf_pkg::OFS_IRQ_MASK, 8'h01);
		arst_n <= 1'h0;
		@(posedge clk_sys);
		arst_n <= 1'h1;
		rd(crf_pkg::OFS_CTRL, 8'h00);
		chk("foreground_receive_buffer", 32'h0, foreground_receive_buffer);
		summarize();
	end
endmodule
